//--- fbc_pkg.sv
// package: constants for the parallel flash host-side bus controller
package fbc_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int SECT_W = 3;
  localparam int SECT_LSB = 16;
  localparam int CLK_PERIOD_NS = 8;
  // strobe timing in ns
  localparam int T_WRITE_LOW_NS = 40;
  localparam int T_WRITE_HIGH_NS = 24;
  localparam int T_ACCESS_NS = 90;
  localparam int T_SETUP_NS = 8;
  localparam int WR_LOW_CYC = (T_WRITE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_HIGH_CYC = (T_WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // command sequence words
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 19'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 19'h002AA;
  localparam logic [DATA_W-1:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [DATA_W-1:0] UNLOCK2_DATA = 8'h55;
  localparam logic [DATA_W-1:0] CMD_RESET = 8'hF0;
  localparam logic [DATA_W-1:0] CMD_ID = 8'h90;
  localparam logic [DATA_W-1:0] CMD_PROG = 8'hA0;
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [DATA_W-1:0] CMD_SECT_ERASE = 8'h30;
  localparam logic [7:0] ID_OFS_MAKER = 8'h00;
  localparam logic [7:0] ID_OFS_DEVICE = 8'h01;
  localparam logic [7:0] ID_OFS_PROTECT = 8'h02;
  // host operations
  typedef enum logic [2:0] {
    FBC_OP_READ = 3'b000,
    FBC_OP_RESET = 3'b001,
    FBC_OP_ID_ENTER = 3'b010,
    FBC_OP_PROGRAM = 3'b011,
    FBC_OP_CHIP_ERASE = 3'b100,
    FBC_OP_SECT_ERASE = 3'b101,
    FBC_OP_RAW_WRITE = 3'b110
  } fbc_op_e;
endpackage

//--- fbc_strobe.sv
// single bus cycle engine: one read or one write on the flash pins
`timescale 1ns/1ns
module fbc_strobe
  import fbc_pkg::*;
#(
  parameter int LOW_CYC = WR_LOW_CYC,
  parameter int HIGH_CYC = WR_HIGH_CYC,
  parameter int RD_CYC = ACC_CYC,
  parameter int SU_CYC = SETUP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic is_write,
  input wire logic [DATA_W-1:0] pin_data_in,
  output logic cs_n,
  output logic og_n,
  output logic ws_n,
  output logic drive,
  output logic done,
  output logic [DATA_W-1:0] rd_data
);
  initial begin
    if (LOW_CYC < 1 || HIGH_CYC < 1 || RD_CYC < 1 || SU_CYC < 1 ||
        LOW_CYC > 256 || HIGH_CYC > 256 || RD_CYC > 256 || SU_CYC > 256) begin
      $error("fbc_strobe: cycle counts must lie between one and 256");
    end
  end

  typedef enum logic [1:0] {
    FBC_S_IDLE = 2'b00,
    FBC_S_SETUP = 2'b01,
    FBC_S_ACTIVE = 2'b10,
    FBC_S_RECOVER = 2'b11
  } fbc_cyc_e;

  fbc_cyc_e state, next_state;
  logic [7:0] cnt, next_cnt;
  logic wr, next_wr;
  logic next_cs_n, next_og_n, next_ws_n, next_drive, next_done;
  logic [DATA_W-1:0] next_rd_data;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wr = wr;
    next_cs_n = cs_n;
    next_og_n = og_n;
    next_ws_n = ws_n;
    next_drive = drive;
    next_done = 1'b0;
    next_rd_data = rd_data;
    case (state)
      FBC_S_IDLE: begin
        if (start) begin
          next_wr = is_write;
          next_cs_n = 1'b0;
          // address and output gate settle before any strobe drops
          next_og_n = 1'b1;
          next_drive = is_write;
          next_cnt = 8'(SU_CYC - 1);
          next_state = FBC_S_SETUP;
        end
      end
      FBC_S_SETUP: begin
        if (cnt == 8'h00) begin
          if (wr) begin
            // write: chip select and write strobe low, output gate high
            next_ws_n = 1'b0;
            next_cnt = 8'(LOW_CYC - 1);
          end else begin
            // read: chip select and output gate low, write strobe high
            next_og_n = 1'b0;
            next_cnt = 8'(RD_CYC - 1);
          end
          next_state = FBC_S_ACTIVE;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      FBC_S_ACTIVE: begin
        if (cnt == 8'h00) begin
          // pulses far longer than the glitch filter width
          if (!wr) begin
            next_rd_data = pin_data_in;
          end
          next_ws_n = 1'b1;
          next_og_n = 1'b1;
          next_cnt = 8'(HIGH_CYC - 1);
          next_state = FBC_S_RECOVER;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      FBC_S_RECOVER: begin
        // data held HIGH_CYC cycles past the strobe rise so it latches cleanly
        if (cnt == 8'h00) begin
          next_cs_n = 1'b1;
          next_drive = 1'b0;
          next_done = 1'b1;
          next_state = FBC_S_IDLE;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      default: next_state = FBC_S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= FBC_S_IDLE;
      cnt <= 8'h00;
      wr <= 1'b0;
      cs_n <= 1'b1;
      og_n <= 1'b1;
      ws_n <= 1'b1;
      drive <= 1'b0;
      done <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      wr <= next_wr;
      cs_n <= next_cs_n;
      og_n <= next_og_n;
      ws_n <= next_ws_n;
      drive <= next_drive;
      done <= next_done;
      rd_data <= next_rd_data;
    end
  end
endmodule

//--- fbc_host.sv
// host-side controller that drives a parallel flash through its pins
`timescale 1ns/1ns
module fbc_host
  import fbc_pkg::*;
#(
  parameter int POLL_LIMIT = 4000
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic REQ_VALID,
  input wire fbc_pkg::fbc_op_e REQ_OP,
  input wire logic [fbc_pkg::ADDR_W-1:0] REQ_ADDR,
  input wire logic [fbc_pkg::DATA_W-1:0] REQ_DATA,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [fbc_pkg::DATA_W-1:0] RSP_DATA,
  output logic RSP_ERROR,
  output logic [fbc_pkg::ADDR_W-1:0] FLASH_ADDR,
  input wire logic [fbc_pkg::DATA_W-1:0] FLASH_DATA_IN,
  output logic [fbc_pkg::DATA_W-1:0] FLASH_DATA_OUT,
  output logic FLASH_DATA_OE,
  output logic FLASH_CS_N,
  output logic FLASH_OG_N,
  output logic FLASH_WS_N
);
  import fbc_pkg::*;

  initial begin
    if (POLL_LIMIT < 1 || POLL_LIMIT > 65535) begin
      $error("fbc_host: POLL_LIMIT out of range");
    end
  end

  // ********************************************************
  // pin input synchroniser
  // ********************************************************
  logic [DATA_W-1:0] din_meta, din_sync;
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      din_meta <= 8'h00;
      din_sync <= 8'h00;
    end else begin
      din_meta <= FLASH_DATA_IN;
      din_sync <= din_meta;
    end
  end

  // ********************************************************
  // sequencer
  // ********************************************************
  typedef enum logic [2:0] {
    FBC_IDLE = 3'b000,
    FBC_ISSUE = 3'b001,
    FBC_WAIT = 3'b010,
    FBC_POLL = 3'b011,
    FBC_POLL_WAIT = 3'b100,
    FBC_RESPOND = 3'b101
  } fbc_state_e;

  fbc_state_e state, next_state;
  fbc_op_e op, next_op;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [DATA_W-1:0] data, next_data;
  logic [2:0] step, next_step;
  logic [15:0] polls, next_polls;
  logic [DATA_W-1:0] last_stat, next_last_stat;
  logic first_poll, next_first_poll;
  logic cyc_start, next_cyc_start;
  logic cyc_write, next_cyc_write;
  logic [ADDR_W-1:0] next_flash_addr;
  logic [DATA_W-1:0] next_flash_data;
  logic next_ready, next_rsp_valid, next_rsp_error;
  logic [DATA_W-1:0] next_rsp_data;
  logic cyc_done;
  logic [DATA_W-1:0] cyc_rd;
  logic cs_n_w, og_n_w, ws_n_w, drive_w;

  // number of write cycles in each sequence
  function automatic logic [2:0] seq_len(input fbc_op_e o);
    case (o)
      FBC_OP_RESET, FBC_OP_RAW_WRITE: seq_len = 3'd1;
      FBC_OP_ID_ENTER: seq_len = 3'd3;
      FBC_OP_PROGRAM: seq_len = 3'd4;
      FBC_OP_CHIP_ERASE, FBC_OP_SECT_ERASE: seq_len = 3'd6;
      default: seq_len = 3'd0;
    endcase
  endfunction

  // each sequence except reset and raw write opens with the two unlock cycles
  function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input fbc_op_e o, input logic [2:0] s,
                                                        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    seq_word = {UNLOCK1_ADDR, UNLOCK1_DATA};
    if (o == FBC_OP_RESET) begin
      seq_word = {a, CMD_RESET};
    end else if (o == FBC_OP_RAW_WRITE) begin
      seq_word = {a, d};
    end else if (s == 3'd1 || s == 3'd4) begin
      seq_word = {UNLOCK2_ADDR, UNLOCK2_DATA};
    end else if (s == 3'd2) begin
      if (o == FBC_OP_ID_ENTER) begin
        seq_word = {UNLOCK1_ADDR, CMD_ID};
      end else if (o == FBC_OP_PROGRAM) begin
        seq_word = {UNLOCK1_ADDR, CMD_PROG};
      end else begin
        seq_word = {UNLOCK1_ADDR, CMD_ERASE_SETUP};
      end
    end else if (s == 3'd3) begin
      seq_word = {a, d};
    end else if (s == 3'd5) begin
      if (o == FBC_OP_CHIP_ERASE) begin
        seq_word = {UNLOCK1_ADDR, CMD_CHIP_ERASE};
      end else begin
        // sector picked by the top address bits only
        seq_word = {a[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b0}}, CMD_SECT_ERASE};
      end
    end
  endfunction

  logic embedded;
  assign embedded = (op == FBC_OP_PROGRAM) || (op == FBC_OP_CHIP_ERASE) || (op == FBC_OP_SECT_ERASE);

  always_comb begin
    next_state = state;
    next_op = op;
    next_addr = addr;
    next_data = data;
    next_step = step;
    next_polls = polls;
    next_last_stat = last_stat;
    next_first_poll = first_poll;
    next_cyc_start = 1'b0;
    next_cyc_write = cyc_write;
    next_flash_addr = FLASH_ADDR;
    next_flash_data = FLASH_DATA_OUT;
    next_ready = REQ_READY;
    next_rsp_valid = 1'b0;
    next_rsp_error = RSP_ERROR;
    next_rsp_data = RSP_DATA;
    case (state)
      FBC_IDLE: begin
        if (REQ_VALID && REQ_READY) begin
          next_op = REQ_OP;
          next_addr = REQ_ADDR;
          next_data = REQ_DATA;
          next_step = 3'd0;
          next_ready = 1'b0;
          next_rsp_error = 1'b0;
          next_state = FBC_ISSUE;
        end
      end
      FBC_ISSUE: begin
        if (op == FBC_OP_READ) begin
          // plain read; also fetches id codes or status when the device is in those modes
          next_flash_addr = addr;
          next_cyc_write = 1'b0;
        end else begin
          {next_flash_addr, next_flash_data} = seq_word(op, step, addr, data);
          next_cyc_write = 1'b1;
        end
        next_cyc_start = 1'b1;
        next_state = FBC_WAIT;
      end
      FBC_WAIT: begin
        if (cyc_done) begin
          next_rsp_data = cyc_rd;
          if (op == FBC_OP_READ) begin
            next_state = FBC_RESPOND;
          end else if (step + 3'd1 < seq_len(op)) begin
            next_step = step + 3'd1;
            next_state = FBC_ISSUE;
          end else if (embedded) begin
            // chip select is released between polls; the operation carries on
            next_polls = 16'h0000;
            next_first_poll = 1'b1;
            next_state = FBC_POLL;
          end else begin
            next_state = FBC_RESPOND;
          end
        end
      end
      FBC_POLL: begin
        next_flash_addr = addr;
        next_cyc_write = 1'b0;
        next_cyc_start = 1'b1;
        next_state = FBC_POLL_WAIT;
      end
      FBC_POLL_WAIT: begin
        if (cyc_done) begin
          next_last_stat = cyc_rd;
          next_first_poll = 1'b0;
          next_polls = polls + 16'h0001;
          // toggle stops when done; the error bit counts only when two toggling reads both show it
          if (!first_poll && (cyc_rd[6] == last_stat[6])) begin
            next_rsp_data = cyc_rd;
            next_state = FBC_RESPOND;
          end else if (cyc_rd[5] && last_stat[5] && !first_poll && (cyc_rd[6] != last_stat[6])) begin
            next_rsp_error = 1'b1;
            next_rsp_data = cyc_rd;
            next_state = FBC_RESPOND;
          end else if (polls == 16'(POLL_LIMIT - 1)) begin
            next_rsp_error = 1'b1;
            next_state = FBC_RESPOND;
          end else begin
            next_state = FBC_POLL;
          end
        end
      end
      FBC_RESPOND: begin
        next_rsp_valid = 1'b1;
        next_ready = 1'b1;
        next_state = FBC_IDLE;
      end
      default: next_state = FBC_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state <= FBC_IDLE;
      op <= FBC_OP_READ;
      addr <= 19'h00000;
      data <= 8'h00;
      step <= 3'd0;
      polls <= 16'h0000;
      last_stat <= 8'h00;
      first_poll <= 1'b0;
      cyc_start <= 1'b0;
      cyc_write <= 1'b0;
      FLASH_ADDR <= 19'h00000;
      FLASH_DATA_OUT <= 8'h00;
      REQ_READY <= 1'b1;
      RSP_VALID <= 1'b0;
      RSP_ERROR <= 1'b0;
      RSP_DATA <= 8'h00;
    end else begin
      state <= next_state;
      op <= next_op;
      addr <= next_addr;
      data <= next_data;
      step <= next_step;
      polls <= next_polls;
      last_stat <= next_last_stat;
      first_poll <= next_first_poll;
      cyc_start <= next_cyc_start;
      cyc_write <= next_cyc_write;
      FLASH_ADDR <= next_flash_addr;
      FLASH_DATA_OUT <= next_flash_data;
      REQ_READY <= next_ready;
      RSP_VALID <= next_rsp_valid;
      RSP_ERROR <= next_rsp_error;
      RSP_DATA <= next_rsp_data;
    end
  end

  // ********************************************************
  // pin strobes
  // ********************************************************
  fbc_strobe u_strobe (
    .clk(CLOCK),
    .rst(RESET),
    .start(cyc_start),
    .is_write(cyc_write),
    .pin_data_in(din_sync),
    .cs_n(cs_n_w),
    .og_n(og_n_w),
    .ws_n(ws_n_w),
    .drive(drive_w),
    .done(cyc_done),
    .rd_data(cyc_rd)
  );

  // strobe module outputs are flops; pins get them directly
  assign FLASH_CS_N = cs_n_w;
  assign FLASH_OG_N = og_n_w;
  assign FLASH_WS_N = ws_n_w;
  assign FLASH_DATA_OE = drive_w;
endmodule

//--- fbc_host_assertions.sv
// checker: pin protocol of the flash host controller
`timescale 1ns/1ns
module fbc_host_assertions
  import fbc_pkg::*;
#(
  parameter int POLL_LIMIT = 4000
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic REQ_VALID,
  input wire fbc_pkg::fbc_op_e REQ_OP,
  input wire logic REQ_READY,
  input wire logic RSP_VALID,
  input wire logic [fbc_pkg::ADDR_W-1:0] FLASH_ADDR,
  input wire logic [fbc_pkg::DATA_W-1:0] FLASH_DATA_OUT,
  input wire logic FLASH_DATA_OE,
  input wire logic FLASH_CS_N,
  input wire logic FLASH_OG_N,
  input wire logic FLASH_WS_N
);
  // ****
  // write index within the sequence of the request taken last
  // ****
  fbc_op_e op, next_op;
  logic [3:0] idx, next_idx;
  logic ws_q, next_ws_q;
  logic seq_op;
  assign seq_op = op != FBC_OP_RESET && op != FBC_OP_RAW_WRITE && op != FBC_OP_READ;
  always_comb begin
    next_op = op;
    next_idx = idx;
    next_ws_q = FLASH_WS_N;
    if (RESET) begin
      next_op = FBC_OP_READ;
      next_idx = 4'h0;
    end else if (REQ_VALID && REQ_READY) begin
      next_op = REQ_OP;
      next_idx = 4'h0;
    end else if (FLASH_WS_N && !ws_q) begin
      next_idx = idx + 4'h1;
    end
  end
  always_ff @(posedge CLOCK) begin
    op <= next_op;
    idx <= next_idx;
    ws_q <= next_ws_q;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  a_read_strobes: assert property (!FLASH_OG_N |-> !FLASH_CS_N && FLASH_WS_N && !FLASH_DATA_OE)
    else $error("output gate low outside a clean read");
  a_write_strobes: assert property (!FLASH_WS_N |-> !FLASH_CS_N && FLASH_OG_N && FLASH_DATA_OE)
    else $error("write strobe low outside a clean write");
  a_write_width: assert property ($fell(FLASH_WS_N) |-> !FLASH_WS_N [*5] ##1 FLASH_WS_N)
    else $error("write strobe width wrong");
  a_write_hold: assert property (!FLASH_WS_N |-> $stable(FLASH_ADDR) && $stable(FLASH_DATA_OUT))
    else $error("address or data moved under write strobe");
  a_read_access: assert property ($fell(FLASH_OG_N) |-> ##12 $rose(FLASH_OG_N))
    else $error("read strobe not held for the access time");
  a_unlock_one: assert property ($fell(FLASH_WS_N) && idx == 4'h0 && seq_op |->
    FLASH_ADDR == UNLOCK1_ADDR && FLASH_DATA_OUT == UNLOCK1_DATA)
    else $error("first unlock write wrong");
  a_unlock_two: assert property ($fell(FLASH_WS_N) && idx == 4'h1 && seq_op |->
    FLASH_ADDR == UNLOCK2_ADDR && FLASH_DATA_OUT == UNLOCK2_DATA)
    else $error("second unlock write wrong");
  a_cmd_word: assert property ($fell(FLASH_WS_N) && idx == 4'h2 && seq_op |-> FLASH_ADDR == UNLOCK1_ADDR &&
    FLASH_DATA_OUT == (op == FBC_OP_ID_ENTER ? CMD_ID : op == FBC_OP_PROGRAM ? CMD_PROG : CMD_ERASE_SETUP))
    else $error("command word wrong");
  a_rsp_pulse: assert property (RSP_VALID |=> !RSP_VALID)
    else $error("response longer than one cycle");
  a_idle_pins: assert property (REQ_READY |-> FLASH_CS_N && FLASH_WS_N && FLASH_OG_N)
    else $error("strobes active while idle");
endmodule
bind fbc_host fbc_host_assertions #(.POLL_LIMIT(POLL_LIMIT)) u_chk (.CLOCK(CLOCK), .RESET(RESET),
  .REQ_VALID(REQ_VALID), .REQ_OP(REQ_OP), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
  .FLASH_ADDR(FLASH_ADDR), .FLASH_DATA_OUT(FLASH_DATA_OUT), .FLASH_DATA_OE(FLASH_DATA_OE),
  .FLASH_CS_N(FLASH_CS_N), .FLASH_OG_N(FLASH_OG_N), .FLASH_WS_N(FLASH_WS_N));

//--- fbc_flash_model.sv
// partner model: byte-wide flash device seen from its pins
`timescale 1ns/1ns
module fbc_flash_model
  import fbc_pkg::*;
#(
  parameter logic [7:0] PROT_MASK = 8'h00,
  parameter logic [7:0] MAKER_CODE = 8'h3C, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h5A, // arbitrary value
  parameter int ACC_NS = 60,
  parameter int BUSY_READS = 3
) (
  input wire logic cs_n,
  input wire logic og_n,
  input wire logic ws_n,
  input wire logic [18:0] addr,
  input wire logic [7:0] dq_in,
  input wire logic id_voltage_bit_hv,
  input wire logic above_lockout,
  output logic [7:0] dq_q,
  output logic dq_en
);
  typedef enum int {ST_ARR, ST_U1, ST_U2, ST_PG, ST_E1, ST_E2, ST_E3, ST_ID, ST_BUSY} fbc_mst_e;
  fbc_mst_e st = ST_ARR;
  logic [7:0] mem [int];
  logic [18:0] wa;
  logic [7:0] pd;
  logic wr_on = 1'b0;
  logic tog = 1'b0;
  logic fail = 1'b0;
  int busy_n = 0;
  int k[$];
  time t0;
  wire sel_d;
  // ****
  // pins
  // ****
  assign #(ACC_NS, 0) sel_d = !cs_n;
  assign dq_en = sel_d && !cs_n && !og_n && ws_n;
  initial dq_q = 8'h00;
  function automatic logic [7:0] rd(input logic [18:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
  endfunction
  task automatic busy(input logic [7:0] d);
    pd = d;
    busy_n = BUSY_READS;
    st = ST_BUSY;
  endtask
  task automatic wr_cmd(input logic [7:0] d);
    logic a5;
    logic a2;
    // upper address bits are ignored in unlock words
    a5 = wa[10:0] == UNLOCK1_ADDR[10:0];
    a2 = wa[10:0] == UNLOCK2_ADDR[10:0];
    // a failed operation stays busy until the reset command or a drop of above_lockout clears it
    if (st == ST_BUSY && !(fail && d == CMD_RESET)) return;
    fail = 1'b0;
    if (d == CMD_RESET) st = ST_ARR;
    else case (st)
      ST_U1: st = (a2 && d == UNLOCK2_DATA) ? ST_U2 : ST_ARR;
      ST_U2: st = !a5 ? ST_ARR : d == CMD_ID ? ST_ID : d == CMD_PROG ? ST_PG : d == CMD_ERASE_SETUP ? ST_E1 : ST_ARR;
      ST_E1: st = (a5 && d == UNLOCK1_DATA) ? ST_E2 : ST_ARR;
      ST_E2: st = (a2 && d == UNLOCK2_DATA) ? ST_E3 : ST_ARR;
      ST_PG: begin
        if (PROT_MASK[wa[18:16]]) st = ST_ARR;
        else begin
          // a zero cannot be programmed back to one: the operation fails
          fail = (rd(wa) & d) != d;
          mem[int'(wa)] = rd(wa) & d;
          busy(d);
        end
      end
      ST_E3: begin
        if (d == CMD_CHIP_ERASE && a5 || d == CMD_SECT_ERASE) begin
          k.delete();
          foreach (mem[i]) if (!PROT_MASK[i[18:16]] && (d == CMD_CHIP_ERASE || i[18:16] == wa[18:16])) k.push_back(i);
          foreach (k[j]) mem.delete(k[j]);
          busy(8'hFF);
        end else st = ST_ARR;
      end
      default: if (st == ST_ARR && a5 && d == UNLOCK1_DATA) st = ST_U1;
    endcase
  endtask
  always @(negedge cs_n or negedge ws_n) begin
    if (!cs_n && !ws_n && og_n) begin
      wa = addr;
      t0 = $time;
      wr_on = 1'b1;
    end
  end
  always @(posedge cs_n or posedge ws_n or negedge og_n) begin
    if (wr_on) begin
      wr_on = 1'b0;
      if (og_n && above_lockout && $time - t0 >= 5) wr_cmd(dq_in);
    end
  end
  always @(negedge above_lockout) begin
    st = ST_ARR;
  end
  always @(negedge og_n or negedge cs_n) begin
    if (!og_n && !cs_n && ws_n) begin
      if (id_voltage_bit_hv && !addr[6]) begin
        // raised id pin with address bit 6 low selects the code table whatever the command state
        dq_q = addr[1] ? {7'h00, PROT_MASK[addr[18:16]]} : addr[0] ? DEV_CODE : MAKER_CODE;
      end else if (st == ST_BUSY) begin
        dq_q = {~pd[7], tog, fail, 5'h00};
        tog = !tog;
        busy_n--;
        if (busy_n == 0 && !fail) st = ST_ARR;
      end else if (st == ST_ID) begin
        dq_q = addr[7:0] == ID_OFS_MAKER ? MAKER_CODE : addr[7:0] == ID_OFS_DEVICE ? DEV_CODE :
          {7'h00, PROT_MASK[addr[18:16]]};
      end else dq_q = rd(addr);
    end
  end
endmodule

//--- fbc_host_tb_top.sv
// testbench: host controller driving a flash device model
`timescale 1ns/1ns
module fbc_host_tb_top;
  import fbc_pkg::*;
  logic CLOCK, RESET, REQ_VALID, REQ_READY, RSP_VALID, RSP_ERROR;
  fbc_op_e REQ_OP;
  logic [ADDR_W-1:0] REQ_ADDR, FLASH_ADDR;
  logic [DATA_W-1:0] REQ_DATA, RSP_DATA, FLASH_DATA_IN, FLASH_DATA_OUT, dq_q;
  logic FLASH_DATA_OE, FLASH_CS_N, FLASH_OG_N, FLASH_WS_N, dq_en, id_hv, vcc_ok;
  int bad_count = 0;
  int total_checks = 0;
  // a released bus shows the inverse of its last value, not a stale copy
  assign FLASH_DATA_IN = FLASH_DATA_OE ? FLASH_DATA_OUT : dq_en ? dq_q : ~dq_q;
  fbc_host #(.POLL_LIMIT(8)) i_dut (.CLOCK(CLOCK), .RESET(RESET), .REQ_VALID(REQ_VALID), .REQ_OP(REQ_OP),
    .REQ_ADDR(REQ_ADDR), .REQ_DATA(REQ_DATA), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
    .RSP_DATA(RSP_DATA), .RSP_ERROR(RSP_ERROR), .FLASH_ADDR(FLASH_ADDR), .FLASH_DATA_IN(FLASH_DATA_IN),
    .FLASH_DATA_OUT(FLASH_DATA_OUT), .FLASH_DATA_OE(FLASH_DATA_OE), .FLASH_CS_N(FLASH_CS_N),
    .FLASH_OG_N(FLASH_OG_N), .FLASH_WS_N(FLASH_WS_N));
  fbc_flash_model #(.PROT_MASK(8'h20)) i_flash (.cs_n(FLASH_CS_N), .og_n(FLASH_OG_N), .ws_n(FLASH_WS_N),
    .addr(FLASH_ADDR), .dq_in(FLASH_DATA_IN), .id_voltage_bit_hv(id_hv), .above_lockout(vcc_ok),
    .dq_q(dq_q), .dq_en(dq_en));
  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end
  // ****
  // shared tasks
  // ****
  task automatic conclude();
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic tick(inout int n, input int lim);
    @(negedge CLOCK);
    n++;
    if (n > lim) begin
      bad_count++;
      conclude();
    end
  endtask
  task automatic req(input fbc_op_e op, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge CLOCK);
    REQ_VALID = 1'b1;
    REQ_OP = op;
    REQ_ADDR = a;
    REQ_DATA = d;
    while (REQ_READY !== 1'b1) tick(n, 50);
    @(negedge CLOCK);
    REQ_VALID = 1'b0;
    while (RSP_VALID !== 1'b1) tick(n, 3000);
  endtask
  task automatic rdchk(input logic [18:0] a, input logic [7:0] e);
    req(FBC_OP_READ, a, 8'h00);
    chk(RSP_DATA, e);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    chk({2'b00, FLASH_DATA_OE, RSP_VALID, REQ_READY, FLASH_CS_N, FLASH_OG_N, FLASH_WS_N}, 8'h0F);
    rdchk(19'h12345, 8'hFF);
  endtask
  task automatic t_program();
    req(FBC_OP_PROGRAM, 19'h10020, 8'h5A);
    chk({7'h00, RSP_ERROR}, 8'h00);
    rdchk(19'h10020, 8'h5A);
    req(FBC_OP_PROGRAM, 19'h50010, 8'h00);
    rdchk(19'h50010, 8'hFF);
  endtask
  task automatic t_ident();
    req(FBC_OP_ID_ENTER, UNLOCK1_ADDR, 8'h00);
    rdchk(19'h00000, 8'h3C);
    rdchk(19'h00001, 8'h5A);
    rdchk(19'h50002, 8'h01);
    rdchk(19'h00002, 8'h00);
    req(FBC_OP_RESET, 19'h7FFFF, CMD_RESET);
    rdchk(19'h10020, 8'h5A);
  endtask
  task automatic t_erase();
    req(FBC_OP_PROGRAM, 19'h20001, 8'h33);
    req(FBC_OP_PROGRAM, 19'h10020, 8'hA5);
    chk({7'h00, RSP_ERROR}, 8'h01);
    req(FBC_OP_RESET, 19'h00000, CMD_RESET);
    req(FBC_OP_SECT_ERASE, 19'h10555, UNLOCK1_DATA);
    chk({7'h00, RSP_ERROR}, 8'h00);
    rdchk(19'h10020, 8'hFF);
    rdchk(19'h20001, 8'h33);
    req(FBC_OP_CHIP_ERASE, UNLOCK1_ADDR, UNLOCK1_DATA);
    rdchk(19'h20001, 8'hFF);
  endtask
  task automatic t_bad_seq();
    req(FBC_OP_PROGRAM, 19'h70003, 8'hC3);
    req(FBC_OP_RAW_WRITE, UNLOCK1_ADDR, UNLOCK1_DATA);
    req(FBC_OP_RAW_WRITE, 19'h00123, 8'h77);
    req(FBC_OP_RAW_WRITE, 19'h70003, 8'h00);
    rdchk(19'h70003, 8'hC3);
  endtask
  task automatic t_guard();
    id_hv = 1'b1;
    rdchk(19'h00000, 8'h3C);
    rdchk(19'h00001, 8'h5A);
    rdchk(19'h50002, 8'h01);
    rdchk(19'h00041, 8'hFF);
    id_hv = 1'b0;
    vcc_ok = 1'b0;
    req(FBC_OP_PROGRAM, 19'h30000, 8'h12);
    vcc_ok = 1'b1;
    rdchk(19'h30000, 8'hFF);
  endtask
  initial begin
    RESET = 1'b1;
    REQ_VALID = 1'b0;
    REQ_OP = FBC_OP_READ;
    REQ_ADDR = '0;
    REQ_DATA = '0;
    id_hv = 1'b0;
    vcc_ok = 1'b1;
    repeat (6) @(negedge CLOCK);
    RESET = 1'b0;
    t_reset();
    t_program();
    t_ident();
    t_erase();
    t_guard();
    t_bad_seq();
    conclude();
  end
endmodule
